// ---- logic/dcps_timer.sv ----
// Down counter with pin control and start/stop handshake.
// Assumes all inputs synchronous to i_clock; count source given as enable.
`timescale 1ns/1ps
// Overview of operation
// RQ1: Dedicated pin off unless enabled, level selectable
// RQ2: Shared pin drives only in pulse mode
// RQ3: Status rises three source cycles after start
// RQ4: Status falls three source cycles after stop
// RQ5: Event or link source uses two CPU cycles
// RQ6: Software waits for status before other access
// RQ7: Software clears pending interrupt before starting
// RQ8: Edge and underflow flags clear only on 0
// RQ9: Software writes control register as whole byte
// RQ10: Counter writes spaced three source cycles apart
// RQ11: Mode registers changed only while stopped
// RQ12: Software clears flags after mode change
// RQ13: Software follows pin output set-up order
// RQ14: Software configures input before starting count
// RQ15: Unused timer: timer mode, pin disabled
// RQ16: Registers inaccessible while clock gate off
// RQ17: Event counting continues with clock gated off
// RQ18: Filter bypassed in low-power event counting
// RQ19: Software waits one source cycle after force stop
// RQ20: Software waits five filter cycles before start
// RQ21: Low-speed source needs supply bit set
// RQ22: Underflow toggles pulse output level
// RQ23: Mode field 010 selects event counting
module dcps_timer
	import dcps_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_timer_clock_gate,
	input wire logic i_low_power_stop,
	input wire logic i_src_tick,
	input wire logic i_src_event_link,
	input wire logic i_wr_start,
	input wire logic i_start_bit,
	input wire logic i_wr_force_stop,
	input wire logic i_wr_flags,
	input wire logic i_active_edge_wdata,
	input wire logic i_underflow_wdata,
	input wire logic i_wr_counter,
	input wire logic [15:0] i_counter_wdata,
	input wire logic i_wr_config,
	input wire logic [2:0] i_op_mode_field,
	input wire logic i_out_pin_enable,
	input wire logic i_level_edge_select,
	input wire logic [1:0] i_input_filter_select,
	input wire logic i_port_direction_bit,
	input wire logic i_shared_pin_in,
	output logic o_timer_out_pin,
	output logic o_timer_out_pin_oe,
	output logic o_shared_pin_out,
	output logic o_shared_pin_oe,
	output logic o_count_start_bit,
	output logic o_count_status_flag,
	output logic o_active_edge_flag,
	output logic o_underflow_flag,
	output logic [15:0] o_counter
);
	dcps_state_t state;
	logic [1:0] sync_cnt;
	logic [2:0] mode;
	logic oena;
	logic edgsel;
	logic [1:0] filt_sel;
	logic [15:0] reload;
	logic toggle;
	logic [2:0] filt_sh;
	logic filt_in;
	logic pin_q;
	logic event_mode;
	logic fast_sync;
	logic tick;
	logic acc;
	logic edge_ev;
	logic underflow_ev;
	logic running;
	logic cnt_tick;

	assign acc = i_timer_clock_gate; // RQ16
	assign event_mode = (mode == DCPS_MODE_EVENT); // RQ23
	assign fast_sync = event_mode || i_src_event_link; // RQ5
	assign tick = fast_sync ? 1'b1 : i_src_tick;
	assign running = (state == DCPS_RUN) || (state == DCPS_STOPPING);

	// Filter is lost in low-power stop, so raw pin used there
	always_comb begin
		if (filt_sel == 2'h0 || i_low_power_stop) begin // RQ18
			filt_in = i_shared_pin_in;
		end else if (filt_sh == 3'h7) begin
			filt_in = 1'b1;
		end else if (filt_sh == 3'h0) begin
			filt_in = 1'b0;
		end else begin
			filt_in = pin_q;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			filt_sh <= 3'h0;
			pin_q <= 1'b0;
		end else begin
			filt_sh <= {filt_sh[1:0], i_shared_pin_in};
			pin_q <= filt_in;
		end
	end

	// Active level of the measured pin follows the level select
	assign edge_ev = ((mode == DCPS_MODE_PWIDTH) && pin_q == edgsel
		&& filt_in != edgsel) || ((mode == DCPS_MODE_PPERIOD)
		&& pin_q != edgsel && filt_in == edgsel);
	always_comb begin
		cnt_tick = 1'b0;
		if (running) begin
			if (event_mode) begin
				cnt_tick = (pin_q != edgsel) && (filt_in == edgsel);
			end else if (mode == DCPS_MODE_PWIDTH) begin
				cnt_tick = i_src_tick && (filt_in == edgsel);
			end else begin
				cnt_tick = i_src_tick;
			end
		end
	end
	assign underflow_ev = cnt_tick && (o_counter == 16'h0000);

	// Configuration, held while the clock gate is off
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			mode <= DCPS_MODE_TIMER;
			oena <= 1'b0;
			edgsel <= 1'b0;
			filt_sel <= 2'h0;
		end else if (acc && i_wr_config) begin // RQ16
			mode <= i_op_mode_field;
			oena <= i_out_pin_enable;
			edgsel <= i_level_edge_select;
			filt_sel <= i_input_filter_select;
		end
	end

	// Start/stop handshake; runs regardless of gate so events go on
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state <= DCPS_IDLE;
			sync_cnt <= 2'h0;
			o_count_start_bit <= 1'b0;
			o_count_status_flag <= 1'b0;
		end else if (acc && i_wr_force_stop) begin
			state <= DCPS_IDLE;
			sync_cnt <= 2'h0;
			o_count_start_bit <= 1'b0;
			o_count_status_flag <= 1'b0;
		end else begin
			if (acc && i_wr_start) begin
				o_count_start_bit <= i_start_bit;
			end
			case (state)
				DCPS_IDLE: begin
					if (acc && i_wr_start && i_start_bit) begin
						state <= DCPS_STARTING;
						sync_cnt <= 2'h0;
					end
				end
				DCPS_STARTING: begin
					if (tick) begin
						if (sync_cnt == (fast_sync ? DCPS_SYNC_CPU
							: DCPS_SYNC_SRC) - 2'h1) begin // RQ3 RQ5
							state <= DCPS_RUN;
							o_count_status_flag <= 1'b1;
						end else begin
							sync_cnt <= sync_cnt + 2'h1;
						end
					end
				end
				DCPS_RUN: begin
					if (acc && i_wr_start && !i_start_bit) begin // RQ17
						state <= DCPS_STOPPING;
						sync_cnt <= 2'h0;
					end
				end
				DCPS_STOPPING: begin
					if (tick) begin
						if (sync_cnt == (fast_sync ? DCPS_SYNC_CPU
							: DCPS_SYNC_SRC) - 2'h1) begin // RQ4 RQ5
							state <= DCPS_IDLE;
							o_count_status_flag <= 1'b0;
						end else begin
							sync_cnt <= sync_cnt + 2'h1;
						end
					end
				end
				default: begin
					state <= DCPS_IDLE;
				end
			endcase
		end
	end

	// Counter; pulse-period capture kept simple as reload on edge
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_counter <= DCPS_CNT_RESET;
			reload <= DCPS_CNT_RESET;
		end else if (acc && i_wr_counter) begin
			o_counter <= i_counter_wdata;
			reload <= i_counter_wdata;
		end else if (underflow_ev) begin
			o_counter <= reload;
		end else if (edge_ev && mode == DCPS_MODE_PPERIOD) begin
			o_counter <= reload;
		end else if (cnt_tick) begin
			o_counter <= o_counter - 16'h0001;
		end
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_active_edge_flag <= 1'b0;
			o_underflow_flag <= 1'b0;
		end else begin
			if (edge_ev && running) begin
				o_active_edge_flag <= 1'b1;
			end else if (acc && i_wr_flags && !i_active_edge_wdata) begin
				o_active_edge_flag <= 1'b0; // RQ8
			end
			if (underflow_ev) begin
				o_underflow_flag <= 1'b1;
			end else if (acc && i_wr_flags && !i_underflow_wdata) begin
				o_underflow_flag <= 1'b0; // RQ8
			end
		end
	end

	// Toggle restarts from the initial level whenever stopped
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			toggle <= 1'b0;
		end else if (!running) begin
			toggle <= 1'b0;
		end else if (underflow_ev) begin
			toggle <= ~toggle; // RQ22
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_timer_out_pin <= 1'b0;
			o_timer_out_pin_oe <= 1'b0;
			o_shared_pin_out <= 1'b0;
			o_shared_pin_oe <= 1'b0;
		end else begin
			o_timer_out_pin_oe <= oena; // RQ1
			o_timer_out_pin <= toggle ^ edgsel; // RQ1
			o_shared_pin_oe <= (mode == DCPS_MODE_PULSE)
				&& !i_port_direction_bit; // RQ2
			o_shared_pin_out <= toggle ^ ~edgsel; // RQ2
		end
	end
endmodule

// ---- pkg/dcps_pkg.sv ----
// Constants and types for the down counter pin and start control block.
// Assumes a single 100 MHz clock domain.
package dcps_pkg;
	localparam int unsigned DCPS_CLK_PERIOD_NS = 10;
	localparam int unsigned DCPS_CNT_W = 16;
	localparam logic [15:0] DCPS_CNT_RESET = 16'hFFFF;
	localparam logic [2:0] DCPS_MODE_TIMER = 3'h0;
	localparam logic [2:0] DCPS_MODE_PULSE = 3'h1;
	localparam logic [2:0] DCPS_MODE_EVENT = 3'h2;
	localparam logic [2:0] DCPS_MODE_PWIDTH = 3'h3;
	localparam logic [2:0] DCPS_MODE_PPERIOD = 3'h4;
	// Start and stop synchronisation lengths
	localparam logic [1:0] DCPS_SYNC_SRC = 2'h3;
	localparam logic [1:0] DCPS_SYNC_CPU = 2'h2;
	typedef enum logic [1:0] {
		DCPS_IDLE,
		DCPS_STARTING,
		DCPS_RUN,
		DCPS_STOPPING
	} dcps_state_t;
endpackage

// ---- verification/dcps_src_model.sv ----
// Count source and shared pin partner.
// Assumes the bench clock; one tick in four cycles.
`timescale 1ns/1ps
module dcps_src_model (
	input wire logic i_clock,
	output logic o_tick = 1'h0,
	output logic o_pin = 1'h0
);
	logic [1:0] ph = 2'h0;
	// Pin toggles every cycle, so a stale level never looks settled
	always @(posedge i_clock) begin
		ph <= #1 ph + 2'h1;
		o_tick <= #1 (ph == 2'h2);
		o_pin <= #1 ~o_pin;
	end
endmodule

// ---- verification/dcps_timer_assertions.sv ----
// Checker for dcps_timer pins, handshake and flags.
// Bound to the design; sees its ports only.
`timescale 1ns/1ps
module dcps_chk (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_timer_clock_gate,
	input wire logic i_wr_flags,
	input wire logic i_active_edge_wdata,
	input wire logic i_underflow_wdata,
	input wire logic i_wr_config,
	input wire logic i_src_event_link,
	input wire logic o_timer_out_pin_oe,
	input wire logic o_shared_pin_oe,
	input wire logic o_count_start_bit,
	input wire logic o_count_status_flag,
	input wire logic o_active_edge_flag,
	input wire logic o_underflow_flag
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	out_oe_a: assert property ($changed(o_timer_out_pin_oe)
		|-> $past(i_wr_config) || $past(i_wr_config, 2)) else $error("oe");
	shared_oe_a: assert property ($changed(o_shared_pin_oe)
		|-> $past(i_wr_config) || $past(i_wr_config, 2)) else $error("soe");
	start_rise_a: assert property ($rose(o_count_status_flag)
		|-> o_count_start_bit) else $error("rise");
	stop_fall_a: assert property ($fell(o_count_status_flag)
		|-> !o_count_start_bit) else $error("fall");
	sync_wait_a: assert property ($rose(o_count_start_bit)
		&& i_src_event_link |-> !o_count_status_flag ##1
		!o_count_status_flag ##1 o_count_status_flag) else $error("sync");
	edge_hold_a: assert property (o_active_edge_flag && !(i_wr_flags
		&& i_timer_clock_gate && !i_active_edge_wdata) |=> o_active_edge_flag)
		else $error("edge");
	undf_hold_a: assert property (o_underflow_flag && !(i_wr_flags
		&& i_timer_clock_gate && !i_underflow_wdata) |=> o_underflow_flag)
		else $error("undf");
	gate_start_a: assert property (!i_timer_clock_gate
		|=> $stable(o_count_start_bit)) else $error("gate");
endmodule
bind dcps_timer dcps_chk i_dcps_chk (.*);

// ---- verification/dcps_timer_tb.sv ----
// Random and corner tests for dcps_timer.
// Assumes the source model for ticks and pin level.
`timescale 1ns/1ps
module dcps_timer_tb;
	import dcps_pkg::*;
	logic i_clock = 1'h0, i_sys_rst = 1'h1, i_timer_clock_gate = 1'h1;
	logic i_low_power_stop = 1'h0, i_src_event_link = 1'h0;
	logic i_wr_start = 1'h0, i_start_bit = 1'h0, i_wr_force_stop = 1'h0;
	logic i_wr_flags = 1'h0, i_active_edge_wdata = 1'h0;
	logic i_underflow_wdata = 1'h0, i_wr_counter = 1'h0, i_wr_config = 1'h0;
	logic i_out_pin_enable = 1'h0, i_level_edge_select = 1'h0;
	logic i_port_direction_bit = 1'h1, i_src_tick, i_shared_pin_in;
	logic [15:0] i_counter_wdata = 16'h0000;
	logic [2:0] i_op_mode_field = 3'h0, m;
	logic [1:0] i_input_filter_select = 2'h0;
	logic o_timer_out_pin, o_timer_out_pin_oe, o_shared_pin_out;
	logic o_shared_pin_oe, o_count_start_bit, o_count_status_flag;
	logic o_active_edge_flag, o_underflow_flag;
	logic [15:0] o_counter;
	logic [31:0] r;
	logic [15:0] snap;
	int n_mismatch = 0, compares = 0, seed = 3069, n;
	always #5 i_clock = ~i_clock;
	dcps_timer i_dcps_timer (.*);
	dcps_src_model i_dcps_src_model (.i_clock(i_clock),
		.o_tick(i_src_tick), .o_pin(i_shared_pin_in));
	function automatic logic sh_oe(logic [2:0] md, logic d);
		return md == DCPS_MODE_PULSE && !d;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(posedge i_clock) #1 s = 1'h0;
	endtask
	task automatic cfg(input logic [2:0] md, input logic [7:0] v);
		i_op_mode_field = md;
		{i_input_filter_select, i_port_direction_bit, i_level_edge_select,
			i_out_pin_enable} = v[4:0];
		pulse(i_wr_config);
		repeat (3) @(posedge i_clock);
		#1;
	endtask
	// Counts ticks, or cycles, until the status flag reaches v
	task automatic go(input logic v, input logic t);
		i_start_bit = v;
		pulse(i_wr_start);
		n = 0;
		for (int i = 0; i < 99; i++) begin
			@(negedge i_clock);
			if (o_count_status_flag === v) break;
			if (!t || i_src_tick === 1'h1) n++;
		end
		@(posedge i_clock) #1;
	endtask
	task automatic final_report;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (4) @(posedge i_clock);
		#1;
		i_sys_rst = 1'h0;
		chk(o_counter, DCPS_CNT_RESET);
		chk({o_count_start_bit, o_count_status_flag, o_underflow_flag,
			o_timer_out_pin_oe, o_shared_pin_oe}, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			m = 3'(i < 5 ? i : r % 5);
			cfg(m, r[7:0]);
			chk(o_timer_out_pin_oe, r[0]);
			if (r[0]) chk(o_timer_out_pin, r[1]);
			chk(o_shared_pin_oe, sh_oe(m, r[2]));
			if (sh_oe(m, r[2])) chk(o_shared_pin_out, !r[1]);
		end
		$display("test pins done");
		for (int k = 0; k < 3; k++) begin
			i_src_event_link = (k == 1);
			cfg(k == 2 ? DCPS_MODE_EVENT : DCPS_MODE_TIMER, 8'h04);
			go(1'h1, k == 0);
			chk(16'(n), k == 0 ? 16'h0003 : 16'h0002);
			go(1'h0, k == 0);
			chk(16'(n), k == 0 ? 16'h0003 : 16'h0002);
		end
		$display("test handshake done");
		i_src_event_link = 1'h0;
		cfg(DCPS_MODE_PULSE, 8'h01);
		i_counter_wdata = 16'h0002;
		pulse(i_wr_counter);
		go(1'h1, 1'h1);
		for (int i = 0; i < 99 && o_underflow_flag !== 1'h1; i++)
			@(negedge i_clock);
		repeat (2) @(posedge i_clock);
		#1;
		chk(o_timer_out_pin, 1'h1);
		chk(o_shared_pin_out, 1'h0);
		go(1'h0, 1'h1);
		{i_active_edge_wdata, i_underflow_wdata} = 2'h3;
		pulse(i_wr_flags);
		chk(o_underflow_flag, 1'h1);
		@(posedge i_clock) #1;
		{i_active_edge_wdata, i_underflow_wdata} = 2'h0;
		pulse(i_wr_flags);
		chk(o_underflow_flag, 1'h0);
		// Measuring modes: toggling pin gives an active edge every 2 cycles
		for (int j = 3; j < 5; j++) begin
			cfg(3'(j), 8'h04);
			{i_active_edge_wdata, i_underflow_wdata} = 2'h0;
			pulse(i_wr_flags);
			chk(o_active_edge_flag, 1'h0);
			go(1'h1, 1'h1);
			repeat (2) @(posedge i_clock);
			#1;
			chk(o_active_edge_flag, 1'h1);
			go(1'h0, 1'h1);
			{i_active_edge_wdata, i_underflow_wdata} = 2'h3;
			pulse(i_wr_flags);
			chk(o_active_edge_flag, 1'h1);
			@(posedge i_clock) #1;
			i_active_edge_wdata = 1'h0;
			pulse(i_wr_flags);
			chk(o_active_edge_flag, 1'h0);
		end
		cfg(DCPS_MODE_TIMER, 8'h04);
		go(1'h1, 1'h1);
		pulse(i_wr_force_stop);
		chk({o_count_start_bit, o_count_status_flag}, 16'h0000);
		repeat (4) @(posedge i_clock);
		#1;
		// Filter on: a pin that never settles must give no events
		i_counter_wdata = 16'h0100;
		cfg(DCPS_MODE_EVENT, 8'h0C);
		pulse(i_wr_counter);
		repeat (5) @(posedge i_clock);
		#1;
		go(1'h1, 1'h0);
		snap = o_counter;
		repeat (10) @(posedge i_clock);
		#1;
		chk(o_counter, snap);
		i_timer_clock_gate = 1'h0;
		i_low_power_stop = 1'h1;
		repeat (2) @(posedge i_clock);
		#1;
		snap = o_counter;
		repeat (10) @(posedge i_clock);
		#1;
		chk(o_counter, snap - 16'h0005);
		i_low_power_stop = 1'h0;
		i_timer_clock_gate = 1'h1;
		go(1'h0, 1'h0);
		chk(o_count_status_flag, 1'h0);
		$display("test modes lowpower done");
		i_counter_wdata = 16'h00AB;
		pulse(i_wr_counter);
		chk(o_counter, 16'h00AB);
		i_timer_clock_gate = 1'h0;
		i_start_bit = 1'h1;
		pulse(i_wr_start);
		i_counter_wdata = 16'h1234;
		pulse(i_wr_counter);
		chk(o_count_start_bit, 1'h0);
		chk(o_counter, 16'h00AB);
		$display("test flags gate done");
		final_report;
	end
endmodule
